// File: hvew_defines.svh
// register addresses, field positions, reset values for the pin edge/wake block
`ifndef HVEW_DEFINES_SVH
`define HVEW_DEFINES_SVH
`define HVEW_ADDR_PIN2 16'ha052
`define HVEW_ADDR_PIN3 16'ha053
`define HVEW_BIT_WAKE_EN 7
`define HVEW_BIT_IRQ_EN 6
`define HVEW_BIT_RISE_EN 5
`define HVEW_BIT_FALL_EN 4
`define HVEW_BIT_WAKE_FLAG 3
`define HVEW_BIT_IRQ_FLAG 2
`define HVEW_BIT_RISE_FLAG 1
`define HVEW_BIT_FALL_FLAG 0
`define HVEW_REG_RESET 8'h00
`define HVEW_NUM_PINS 2
`endif

// File: hvew_pkg.sv
// types shared by the pin edge/wake block
package hvew_pkg;
  // one control register: enables in the high nibble, sticky flags in the low
  typedef struct packed {
    logic wake_enable;
    logic irq_enable;
    logic rise_enable;
    logic fall_enable;
    logic wake_flag;
    logic irq_flag;
    logic rise_flag;
    logic fall_flag;
  } hvew_ctrl_type;
  // special function register access from the processor
  typedef struct packed {
    logic [15:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } hvew_sfr_req_type;
endpackage : hvew_pkg

// File: hvew_edge_cell.sv
// per-pin edge detector and sticky flag logic
`include "hvew_defines.svh"
module hvew_edge_cell
  import hvew_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // pin level
  input wire logic pin_level,
  // register write from software
  input wire logic wr_en,
  input wire logic [7:0] wdata,
  // register contents
  output hvew_ctrl_type ctrl,
  output logic irq_req,
  output logic wake_req
);
  logic pin_prev;
  logic rise_seen;
  logic fall_seen;
  logic event_seen;
  hvew_ctrl_type wr_val;
  hvew_ctrl_type next_ctrl;

  assign wr_val = hvew_ctrl_type'(wdata);
  assign rise_seen = pin_level & ~pin_prev;
  assign fall_seen = ~pin_level & pin_prev;
  // an event is an edge in a direction that is enabled
  assign event_seen = (rise_seen & ctrl.rise_enable) | (fall_seen & ctrl.fall_enable);

  always_comb
  begin
    next_ctrl = ctrl;
    if (wr_en)
    begin
      next_ctrl.wake_enable = wr_val.wake_enable;
      next_ctrl.irq_enable = wr_val.irq_enable;
      next_ctrl.rise_enable = wr_val.rise_enable;
      next_ctrl.fall_enable = wr_val.fall_enable;
      // writing zero clears a flag, writing one leaves it alone
      next_ctrl.wake_flag = ctrl.wake_flag & wr_val.wake_flag;
      next_ctrl.irq_flag = ctrl.irq_flag & wr_val.irq_flag;
      next_ctrl.rise_flag = ctrl.rise_flag & wr_val.rise_flag;
      next_ctrl.fall_flag = ctrl.fall_flag & wr_val.fall_flag;
    end
    // set beats a clear in the same cycle so no event is lost
    if (ctrl.wake_enable & event_seen)
      next_ctrl.wake_flag = 1'b1;
    if (ctrl.irq_enable & event_seen)
      next_ctrl.irq_flag = 1'b1;
    if (ctrl.rise_enable & rise_seen)
      next_ctrl.rise_flag = 1'b1;
    if (ctrl.fall_enable & fall_seen)
      next_ctrl.fall_flag = 1'b1;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl <= hvew_ctrl_type'(`HVEW_REG_RESET);
      pin_prev <= 1'b0;
    end
    else
    begin
      ctrl <= next_ctrl;
      pin_prev <= pin_level;
    end
  end

  assign irq_req = ctrl.irq_flag;
  assign wake_req = ctrl.wake_flag;

  chk_rise_flag_set: assert property (@(posedge clock) disable iff (!rst_n)
    (ctrl.rise_enable && rise_seen) |=> ctrl.rise_flag)
    else $error("rise flag not set after enabled rising edge");
  chk_fall_flag_set: assert property (@(posedge clock) disable iff (!rst_n)
    (ctrl.fall_enable && fall_seen) |=> ctrl.fall_flag)
    else $error("fall flag not set after enabled falling edge");
  chk_irq_flag_set: assert property (@(posedge clock) disable iff (!rst_n)
    (ctrl.irq_enable && event_seen) |=> ctrl.irq_flag)
    else $error("irq flag not set after enabled event");
  chk_wake_flag_set: assert property (@(posedge clock) disable iff (!rst_n)
    (ctrl.wake_enable && event_seen) |=> ctrl.wake_flag)
    else $error("wake flag not set after enabled event");
  chk_irq_flag_sticky: assert property (@(posedge clock) disable iff (!rst_n)
    (ctrl.irq_flag && !wr_en) |=> ctrl.irq_flag)
    else $error("irq flag dropped without software clear");
  chk_rise_flag_quiet: assert property (@(posedge clock) disable iff (!rst_n)
    (!ctrl.rise_flag && !(ctrl.rise_enable && rise_seen)) |=> !ctrl.rise_flag)
    else $error("rise flag set without enabled rising edge");
endmodule : hvew_edge_cell

// File: hvew_pin_flags.sv
// edge, interrupt and wake flag registers for high-voltage pins two and three
`include "hvew_defines.svh"
module hvew_pin_flags
  import hvew_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // special function register port
  input hvew_sfr_req_type sfr_req,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  // high-voltage pin levels, index 0 is pin two, index 1 is pin three
  input wire logic [`HVEW_NUM_PINS-1:0] high_voltage_io,
  // outputs
  output logic shared_ext_pin_irq_line,
  output logic wake_request
);
  // ==========================================================
  // address decode
  logic [`HVEW_NUM_PINS-1:0] sel;
  logic [`HVEW_NUM_PINS-1:0] wr_sel;
  logic [`HVEW_NUM_PINS-1:0] irq_req;
  logic [`HVEW_NUM_PINS-1:0] wake_req;
  hvew_ctrl_type ctrl [`HVEW_NUM_PINS];
  logic [7:0] next_rdata;

  // both registers decode the same way, so the compare lives in one place
  function automatic logic addr_match(input logic [15:0] addr, input logic [15:0] base);
    return addr == base;
  endfunction : addr_match

  assign sel[0] = addr_match(sfr_req.addr, `HVEW_ADDR_PIN2);
  assign sel[1] = addr_match(sfr_req.addr, `HVEW_ADDR_PIN3);
  assign sfr_hit = |sel;
  // a write to an unmapped address reaches no cell, so it is simply dropped
  assign wr_sel = {`HVEW_NUM_PINS{sfr_req.wr}} & sel;

  // ==========================================================
  // per-pin cells
  generate
    for (genvar i = 0; i < `HVEW_NUM_PINS; i++)
    begin : g_pin
      hvew_edge_cell u_cell (
        .clock(clock),
        .rst_n(rst_n),
        .pin_level(high_voltage_io[i]),
        .wr_en(wr_sel[i]),
        .wdata(sfr_req.wdata),
        .ctrl(ctrl[i]),
        .irq_req(irq_req[i]),
        .wake_req(wake_req[i])
      );
    end
  endgenerate

  // ==========================================================
  // read data and outputs
  // unmapped addresses read as zero
  assign next_rdata = sel[0] ? 8'(ctrl[0]) : (sel[1] ? 8'(ctrl[1]) : 8'h00);

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      sfr_rdata <= 8'h00;
    else if (sfr_req.rd)
      sfr_rdata <= next_rdata;
  end

  // one shared line rather than a vector per pin; software polls flags for the source
  assign shared_ext_pin_irq_line = |irq_req;
  assign wake_request = |wake_req;

  chk_shared_irq_line: assert property (@(posedge clock) disable iff (!rst_n)
    (ctrl[0].irq_flag || ctrl[1].irq_flag) == shared_ext_pin_irq_line)
    else $error("shared interrupt line disagrees with flags");
  chk_read_pin3: assert property (@(posedge clock) disable iff (!rst_n)
    (sfr_req.rd && sel[1]) |=> sfr_rdata == $past(8'(ctrl[1])))
    else $error("pin three register read mismatch");
  chk_read_pin2: assert property (@(posedge clock) disable iff (!rst_n)
    (sfr_req.rd && sel[0]) |=> sfr_rdata == $past(8'(ctrl[0])))
    else $error("pin two register read mismatch");
  chk_fall_flag_pin3: assert property (@(posedge clock) disable iff (!rst_n)
    (ctrl[1].fall_enable && $fell(high_voltage_io[1])) |=> ctrl[1].fall_flag)
    else $error("pin three fall flag missed");
  chk_wake_flag_pin2: assert property (@(posedge clock) disable iff (!rst_n)
    (ctrl[0].wake_flag && !(sfr_req.wr && sel[0])) |=> ctrl[0].wake_flag)
    else $error("pin two wake flag dropped");
  chk_flag_clear: assert property (@(posedge clock) disable iff (!rst_n)
    (sfr_req.wr && sel[1] && !sfr_req.wdata[`HVEW_BIT_RISE_FLAG] && !$rose(high_voltage_io[1]))
    |=> !ctrl[1].rise_flag)
    else $error("zero write did not clear rise flag");

  // ==========================================================
  // bus-side checks and the wake request summary
  chk_unmapped_read: assert property (@(posedge clock) disable iff (!rst_n)
    (sfr_req.rd && !sfr_hit)
    |=> sfr_rdata == 8'h00)
    else $error("unmapped address did not read zero");

  // software may read the word long after the strobe, so it must not drift
  chk_rdata_hold: assert property (@(posedge clock) disable iff (!rst_n)
    !sfr_req.rd
    |=> $stable(sfr_rdata))
    else $error("read data changed without a read");

  chk_wake_summary: assert property (@(posedge clock) disable iff (!rst_n)
    (ctrl[0].wake_flag || ctrl[1].wake_flag)
    == wake_request)
    else $error("wake request disagrees with wake flags");

  // ==========================================================
  // per-pin checks
  // edges are taken from the pin itself, so a broken detector in the cell is caught here
  generate
    for (genvar i = 0; i < `HVEW_NUM_PINS; i++)
    begin : g_chk
      chk_rise_edge_flag: assert property (@(posedge clock) disable iff (!rst_n)
        (ctrl[i].rise_enable && $rose(high_voltage_io[i]))
        |=> ctrl[i].rise_flag)
        else $error("rise flag missed an enabled rising edge");

      chk_fall_edge_flag: assert property (@(posedge clock) disable iff (!rst_n)
        (ctrl[i].fall_enable && $fell(high_voltage_io[i]))
        |=> ctrl[i].fall_flag)
        else $error("fall flag missed an enabled falling edge");

      chk_irq_event_flag: assert property (@(posedge clock) disable iff (!rst_n)
        (ctrl[i].irq_enable
          && ((ctrl[i].rise_enable && $rose(high_voltage_io[i]))
          || (ctrl[i].fall_enable && $fell(high_voltage_io[i]))))
        |=> ctrl[i].irq_flag)
        else $error("irq flag missed an enabled event");

      chk_wake_event_flag: assert property (@(posedge clock) disable iff (!rst_n)
        (ctrl[i].wake_enable
          && ((ctrl[i].rise_enable && $rose(high_voltage_io[i]))
          || (ctrl[i].fall_enable && $fell(high_voltage_io[i]))))
        |=> ctrl[i].wake_flag)
        else $error("wake flag missed an enabled event");

      chk_irq_flag_hold: assert property (@(posedge clock) disable iff (!rst_n)
        (ctrl[i].irq_flag && !wr_sel[i])
        |=> ctrl[i].irq_flag)
        else $error("irq flag dropped without a write");

      chk_rise_flag_hold: assert property (@(posedge clock) disable iff (!rst_n)
        (ctrl[i].rise_flag && !wr_sel[i])
        |=> ctrl[i].rise_flag)
        else $error("rise flag dropped without a write");

      chk_fall_flag_hold: assert property (@(posedge clock) disable iff (!rst_n)
        (ctrl[i].fall_flag && !wr_sel[i])
        |=> ctrl[i].fall_flag)
        else $error("fall flag dropped without a write");

      chk_wake_flag_hold: assert property (@(posedge clock) disable iff (!rst_n)
        (ctrl[i].wake_flag && !wr_sel[i])
        |=> ctrl[i].wake_flag)
        else $error("wake flag dropped without a write");

      // writing a one to a flag must never create one
      chk_irq_no_source: assert property (@(posedge clock) disable iff (!rst_n)
        (!ctrl[i].irq_flag && !ctrl[i].irq_enable)
        |=> !ctrl[i].irq_flag)
        else $error("irq flag set while disabled");

      chk_wake_no_source: assert property (@(posedge clock) disable iff (!rst_n)
        (!ctrl[i].wake_flag && !ctrl[i].wake_enable)
        |=> !ctrl[i].wake_flag)
        else $error("wake flag set while disabled");

      chk_fall_quiet: assert property (@(posedge clock) disable iff (!rst_n)
        (!ctrl[i].fall_flag && !(ctrl[i].fall_enable && $fell(high_voltage_io[i])))
        |=> !ctrl[i].fall_flag)
        else $error("fall flag set without enabled falling edge");

      chk_enable_write: assert property (@(posedge clock) disable iff (!rst_n)
        wr_sel[i]
        |=> ctrl[i][`HVEW_BIT_WAKE_EN:`HVEW_BIT_FALL_EN] == $past(sfr_req.wdata[7:4]))
        else $error("enable bits did not take the written value");

      chk_enables_kept: assert property (@(posedge clock) disable iff (!rst_n)
        !wr_sel[i]
        |=> $stable(ctrl[i][`HVEW_BIT_WAKE_EN:`HVEW_BIT_FALL_EN]))
        else $error("enable bits changed without a write");

      chk_irq_zero_clear: assert property (@(posedge clock) disable iff (!rst_n)
        (wr_sel[i] && !sfr_req.wdata[`HVEW_BIT_IRQ_FLAG]
          && !(ctrl[i].irq_enable
          && ((ctrl[i].rise_enable && $rose(high_voltage_io[i]))
          || (ctrl[i].fall_enable && $fell(high_voltage_io[i])))))
        |=> !ctrl[i].irq_flag)
        else $error("zero write did not clear irq flag");

      chk_wake_zero_clear: assert property (@(posedge clock) disable iff (!rst_n)
        (wr_sel[i] && !sfr_req.wdata[`HVEW_BIT_WAKE_FLAG]
          && !(ctrl[i].wake_enable
          && ((ctrl[i].rise_enable && $rose(high_voltage_io[i]))
          || (ctrl[i].fall_enable && $fell(high_voltage_io[i])))))
        |=> !ctrl[i].wake_flag)
        else $error("zero write did not clear wake flag");

      chk_fall_zero_clear: assert property (@(posedge clock) disable iff (!rst_n)
        (wr_sel[i] && !sfr_req.wdata[`HVEW_BIT_FALL_FLAG]
          && !(ctrl[i].fall_enable && $fell(high_voltage_io[i])))
        |=> !ctrl[i].fall_flag)
        else $error("zero write did not clear fall flag");
    end
  endgenerate
endmodule : hvew_pin_flags

// File: hvew_pin_model.sv
// far-side model: external sources driving high-voltage pins two and three
module hvew_pin_model
(
  // clock
  input wire logic clock,
  // levels asked for by the bench
  input wire logic [1:0] target,
  // pin levels toward the block
  output logic [1:0] level
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // pin drive
  // levels move just after an edge, so the block never samples a changing pin
  initial level = 2'h0;
  always @(posedge clock)
    level <= target;
endmodule : hvew_pin_model

// File: hvew_pin_flags_tb.sv
// self-checking bench for the pin edge and wake flag block
`include "hvew_defines.svh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
module hvew_pin_flags_tb
  import hvew_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock;
  logic rst_n;
  hvew_sfr_req_type sfr_req;
  logic [7:0] sfr_rdata;
  logic sfr_hit;
  logic irq_line;
  logic wake_req;
  logic [1:0] target;
  logic [1:0] pins;
  int err_count = 0;
  int check_count = 0;
  int cycles = 0;
  int mreg [2] = '{0, 0};
  int p;
  int q;
  bit rise;
  int set_bits;
  logic [7:0] rdat;
  // ==========================================
  // design and far side
  hvew_pin_flags DUT (.clock(clock), .rst_n(rst_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .sfr_hit(sfr_hit), .high_voltage_io(pins), .shared_ext_pin_irq_line(irq_line),
    .wake_request(wake_req));
  hvew_pin_model pin_model (.clock(clock), .target(target), .level(pins));
  // ==========================================
  // bus tasks and reference model
  task automatic wr(int q, logic [7:0] d);
    @(posedge clock) sfr_req <= '{16'(`HVEW_ADDR_PIN2 + q), 1'b1, 1'b0, d};
    @(posedge clock) sfr_req.wr <= 1'b0;
    if (q < 2)
      mreg[q] = (d & 8'hf0) | (d & mreg[q] & 8'h0f);
  endtask : wr
  task automatic rd(logic [15:0] a, output logic [7:0] d);
    @(posedge clock) sfr_req <= '{a, 1'b0, 1'b1, 8'h00};
    @(posedge clock) sfr_req.rd <= 1'b0;
    #1 d = sfr_rdata;
  endtask : rd
  // an event is an edge in an enabled direction; it also feeds irq and wake
  function automatic int edge_bits(int r, bit up);
    if (up ? mreg[r][5] : mreg[r][4])
      return (up ? 2 : 1) | (int'(mreg[r][6]) << 2) | (int'(mreg[r][7]) << 3);
    return 0;
  endfunction : edge_bits
  // third address is unmapped and must read zero
  task automatic check_all();
    logic [7:0] d;
    for (int a = 0; a < 3; a++)
    begin
      rd(16'(`HVEW_ADDR_PIN2 + a), d);
      `CHK("sfr_rdata", (a < 2) ? 8'(mreg[a]) : 8'h00, d)
      `CHK("sfr_hit", 1'(a < 2), sfr_hit)
    end
    `CHK("irq_line", 1'(mreg[0][2] | mreg[1][2]), irq_line)
    `CHK("wake_request", 1'(mreg[0][3] | mreg[1][3]), wake_req)
  endtask : check_all
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  // ==========================================
  // clock, timeout and main sequence
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_count++;
      end_of_test();
    end
  end
  initial
  begin
    rst_n = 1'b0;
    sfr_req = '0;
    target = 2'h0;
    void'($urandom(32'ha5e85b8f));
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    check_all();
    $display("test reset values done");
    // random writes, some to the unmapped address, then one pin edge per round;
    // odd rounds land the edge on the write cycle, where old enables apply and set beats clear
    for (int i = 0; i < 60; i++)
    begin
      p = $urandom_range(1, 0);
      q = $urandom_range(2, 0);
      rise = !target[p];
      set_bits = edge_bits(p, rise);
      if (i % 2 == 0)
      begin
        wr(q, 8'($urandom));
        set_bits = edge_bits(p, rise);
        @(posedge clock) target[p] <= rise;
        repeat (4) @(posedge clock);
      end
      else
      begin
        @(posedge clock) target[p] <= rise;
        wr(q, 8'($urandom));
        repeat (3) @(posedge clock);
      end
      mreg[p] = mreg[p] | set_bits;
      check_all();
    end
    $display("test random edges done");
    // leave a nonzero word in the read register, then reset in mid-run
    wr(1, 8'hf0);
    rd(`HVEW_ADDR_PIN3, rdat);
    `CHK("sfr_rdata", 8'(mreg[1]), rdat)
    @(posedge clock) rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    mreg = '{0, 0};
    #1 `CHK("sfr_rdata", 8'h00, sfr_rdata)
    check_all();
    $display("test mid-run reset done");
    end_of_test();
  end
endmodule : hvew_pin_flags_tb
